/* hw/ddrrd_pkg.sv */
// Constants, field layouts and carrier types for the DRAM read burst sequencer.
// Assumes every user refers to these names with the package scope written out.
package ddrrd_pkg;

    // Register port
    localparam int          ADDR_W        = 4;
    localparam logic [3:0]  REG_CTRL      = 4'h0;
    localparam logic [3:0]  REG_STAT      = 4'h4;
    localparam logic [3:0]  REG_CNT       = 4'h8;

    // Control register fields
    localparam int          CTRL_BL_LSB   = 0;
    localparam int          CTRL_RPRE_BIT = 2;
    localparam int          CTRL_AL_LSB   = 4;
    localparam int          CTRL_CL_LSB   = 8;
    localparam int          CL_W          = 6;

    // Status register fields (bank open bits sit in 15:0)
    localparam int          STAT_DATA_BIT = 16;
    localparam int          STAT_PRE_BIT  = 17;

    // Burst length field codes; code 2'h3 behaves as fixed 8
    localparam logic [1:0]  BL_FIX8       = 2'h0;
    localparam logic [1:0]  BL_OTF        = 2'h1;
    localparam logic [1:0]  BL_FIX4       = 2'h2;

    // Additive latency codes
    localparam logic [1:0]  AL_OFF        = 2'h0;
    localparam logic [1:0]  AL_CL1        = 2'h1;
    localparam logic [1:0]  AL_CL2        = 2'h2;

    // Reset values
    localparam logic [1:0]  BL_RST        = 2'h0;
    localparam logic [1:0]  AL_RST        = 2'h0;
    localparam logic [5:0]  CL_RST        = 6'h0b;

    // Address bits sampled with a read
    localparam int          A10_BIT       = 10;
    localparam int          A12_BIT       = 12;

    // Burst sizes in beats and in command clocks
    localparam logic [3:0]  BEATS_BL8     = 4'h8;
    localparam logic [3:0]  BEATS_BC4     = 4'h4;
    localparam logic [2:0]  CKS_BL8       = 3'h4;
    localparam logic [2:0]  CKS_BC4       = 3'h2;

    // Command codes on the command pins
    localparam logic [2:0]  CMD_NOP       = 3'h0;
    localparam logic [2:0]  CMD_ACT       = 3'h1;
    localparam logic [2:0]  CMD_RD        = 3'h2;
    localparam logic [2:0]  CMD_WR        = 3'h3;
    localparam logic [2:0]  CMD_PRE       = 3'h4;

    // Data bus owner states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_PREAM = 3'b010,
        ST_DATA  = 3'b100
    } ddrrd_state_t;

    // Command as sampled at a command clock rising edge
    typedef struct packed {
        logic [13:0] addr;
        logic [3:0]  bank;
        logic [2:0]  code;
    } ddrrd_cmd_t;

    // One scheduled read burst
    typedef struct packed {
        logic        vld;
        logic        chop;
        logic        ap;
        logic [3:0]  bank;
        logic [9:0]  col;
    } ddrrd_slot_t;

endpackage

/* hw/ddrrd_sync.sv */
// Two-stage synchroniser for a pin bus, with edge detection on bit 0.
// Assumes bit 0 carries the command clock and the other bits are stable around its rising edges.
`timescale 1ns/1ps
`default_nettype none
module ddrrd_sync #(
    parameter int W = 22
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Raw pins and synchronised view
    input  wire logic [W-1:0] raw_i,
    output logic      [W-1:0] sync_o,
    output logic              rise_o,
    output logic              fall_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic         last_r;

    // Only the second stage looks at the first, to contain metastability
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            sync_r <= '0;
            last_r <= 1'b0;
        end else begin
            meta_r <= raw_i;
            sync_r <= meta_r;
            last_r <= sync_r[0];
        end
    end

    // Edges of the synchronised clock
    assign sync_o = sync_r;
    assign rise_o = sync_r[0] & ~last_r;
    assign fall_o = ~sync_r[0] & last_r;
endmodule
`default_nettype wire

/* hw/ddrrd_seq.sv */
// DRAM read burst sequencer: takes read commands, schedules bursts at read latency,
// drives strobe preamble, data beats and auto precharge. Command clock is a sampled pin.
// Assumes the controller keeps its spacing duties and holds each command a full clock.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// How it works
// (RULE1) Reads run fixed 8-beat, fixed 4-beat chop, or per-command choice.
// (RULE2) In per-command mode address bit 12 low chops to 4, high gives 8.
// (RULE3) Burst field codes: 00 fixed 8, 01 per-command, 10 fixed chop.
// (RULE4) Address bit 10 low: plain read, bank stays open afterwards.
// (RULE5) Address bit 10 high: bank precharges itself after the burst.
// (RULE6) Eight-beat data starts at read latency, bus freed four clocks later.
// (RULE7) Chopped data frees the bus two clocks after read latency.
// (RULE8) Read latency is additive plus CAS latency; additive may be CAS minus one.
// (RULE9) With two-clock preamble the controller never spaces reads five clocks.
// (RULE10) Reads four clocks apart to other bank groups are accepted, any mix.
// (RULE11) One-clock preamble reads five clocks apart leave a gap between bursts.
// (RULE12) At latency 11 a write may follow an 8-beat read eight clocks later.
// (RULE13) Controller should raise write latency by one with two-clock write preamble.
// (RULE14) Controller spaces read to write by the latency and burst difference rule.
// (RULE15) Controller spaces read to precharge by additive latency plus read-to-precharge.
// (RULE16) Strobe preamble of programmed length precedes a burst leaving an idle bus.
module ddrrd_seq #(
    parameter int DQ_W  = 8,
    parameter int DEPTH = 64
) (
    // System clock and reset
    input  wire logic                        SYS_CLK_I,
    input  wire logic                        SYS_RST_I,
    // Command clock and command pins
    input  wire logic                        CK_I,
    input  wire logic [2:0]                  CMD_I,
    input  wire logic [3:0]                  BA_I,
    input  wire logic [13:0]                 ADDR_I,
    // Register port
    input  wire logic [ddrrd_pkg::ADDR_W-1:0] REG_ADDR_I,
    input  wire logic [31:0]                 REG_WDATA_I,
    input  wire logic                        REG_WR_I,
    input  wire logic                        REG_RD_I,
    output logic      [31:0]                 REG_RDATA_O,
    // Data and strobe pins
    output logic      [DQ_W-1:0]             DQ_O,
    output logic                             DQ_OE_O,
    output logic                             DQS_O,
    output logic                             DQS_OE_O
);
    localparam int IDX_W = $clog2(DEPTH);

    logic [21:0]            pin_q;
    logic                   ck_rise;
    logic                   ck_fall;
    ddrrd_pkg::ddrrd_cmd_t  cmd_w;
    logic [1:0]             bl_mode_r;
    logic                   rpre2_r;
    logic [1:0]             al_mode_r;
    logic [5:0]             cl_r;
    logic [15:0]            rd_cnt_r;
    logic [15:0]            bank_open_r;
    logic [31:0]            rdata_r;
    ddrrd_pkg::ddrrd_slot_t slot_r   [DEPTH];
    ddrrd_pkg::ddrrd_slot_t slot_src [DEPTH];
    ddrrd_pkg::ddrrd_state_t state_r, state_nxt;
    ddrrd_pkg::ddrrd_slot_t cur_r, cur_nxt;
    logic [3:0]             left_r, left_nxt;
    logic [2:0]             beat_r, beat_nxt;
    logic [DQ_W-1:0]        dq_r, dq_nxt;
    logic                   dq_oe_r, dq_oe_nxt;
    logic                   dqs_r, dqs_nxt;
    logic                   dqs_oe_r, dqs_oe_nxt;
    logic                   act_start, act_pre, act_stop, act_beat;
    logic [2:0]             rise_cnt_r;

    // Pins cross into the system clock through two flops
    ddrrd_sync #(.W(22)) u_sync (
        .clk_i  (SYS_CLK_I),
        .rst_i  (SYS_RST_I),
        .raw_i  ({ADDR_I, BA_I, CMD_I, CK_I}),
        .sync_o (pin_q),
        .rise_o (ck_rise),
        .fall_o (ck_fall)
    );

    // Command decode and latency arithmetic; a write decodes to nothing here,
    // so a write that trails a read never disturbs the read burst
    wire       cmd_edge = ck_rise;
    assign     cmd_w    = ddrrd_pkg::ddrrd_cmd_t'(pin_q[21:1]);
    wire       rd_take  = cmd_edge && (cmd_w.code == ddrrd_pkg::CMD_RD);     // [RULE12]
    wire       act_take = cmd_edge && (cmd_w.code == ddrrd_pkg::CMD_ACT);
    wire       pre_take = cmd_edge && (cmd_w.code == ddrrd_pkg::CMD_PRE);
    wire [5:0] al_w     = (al_mode_r == ddrrd_pkg::AL_CL1) ? cl_r - 6'h01 :     // [RULE8]
                          (al_mode_r == ddrrd_pkg::AL_CL2) ? cl_r - 6'h02 : 6'h00;
    wire [6:0] rl_w     = {1'b0, cl_r} + {1'b0, al_w};                          // [RULE8]
    wire [IDX_W-1:0] rl_idx = IDX_W'(rl_w - 7'h01);
    wire       otf_w    = (bl_mode_r == ddrrd_pkg::BL_OTF);
    wire       chop_w   = (bl_mode_r == ddrrd_pkg::BL_FIX4) ||                  // [RULE3]
                          (otf_w && !cmd_w.addr[ddrrd_pkg::A12_BIT]);           // [RULE2]
    ddrrd_pkg::ddrrd_slot_t new_slot;
    assign new_slot = '{vld: 1'b1, chop: chop_w, ap: cmd_w.addr[ddrrd_pkg::A10_BIT],
                        bank: cmd_w.bank, col: cmd_w.addr[9:0]};               // [RULE1]

    // Latency pipeline: one slot per command clock, head reached at read latency.
    // Reads are taken on every rising edge with no spacing check, so four-clock spacing works.
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_slot
            if (g == DEPTH - 1) begin : g_last
                assign slot_src[g] = '0;
            end else begin : g_mid
                assign slot_src[g] = slot_r[g+1];
            end
            always_ff @(posedge SYS_CLK_I) begin
                if (SYS_RST_I) begin
                    slot_r[g] <= '0;
                end else if (ck_rise) begin
                    slot_r[g] <= (rd_take && rl_idx == IDX_W'(g)) ? new_slot   // [RULE10]
                                                                  : slot_src[g];
                end
            end
        end
    endgenerate

    // Burst timing terms; preamble looks one or two clocks ahead of the head
    wire start_w  = slot_r[0].vld;
    wire look_w   = rpre2_r ? slot_r[2].vld : slot_r[1].vld;                    // [RULE16]
    wire ending_w = (state_r == ddrrd_pkg::ST_DATA) && (left_r == 4'h0);
    wire ap_close = ck_rise && ending_w && cur_r.ap;                            // [RULE5]

    // Data bus owner: pick the action for this system cycle
    always_comb begin
        act_start = 1'b0;
        act_pre   = 1'b0;
        act_stop  = 1'b0;
        act_beat  = 1'b0;
        unique case (state_r)
            ddrrd_pkg::ST_IDLE: begin
                act_start = ck_rise && start_w;
                act_pre   = ck_rise && !start_w && look_w;
            end
            ddrrd_pkg::ST_PREAM: begin
                act_start = ck_rise && start_w;
            end
            ddrrd_pkg::ST_DATA: begin
                act_start = ck_rise && ending_w && start_w;                    // [RULE10]
                act_pre   = ck_rise && ending_w && !start_w && look_w;          // [RULE11]
                act_stop  = ck_rise && ending_w && !start_w && !look_w;
                act_beat  = (ck_rise || ck_fall) && !ending_w;
            end
        endcase
    end

    // Next values of the pin drivers; strobe rises with the clock, falls with it
    always_comb begin
        state_nxt  = state_r;
        cur_nxt    = cur_r;
        left_nxt   = left_r;
        beat_nxt   = beat_r;
        dq_nxt     = dq_r;
        dq_oe_nxt  = dq_oe_r;
        dqs_nxt    = dqs_r;
        dqs_oe_nxt = dqs_oe_r;
        if (act_start) begin
            state_nxt  = ddrrd_pkg::ST_DATA;                                    // [RULE6]
            cur_nxt    = slot_r[0];
            left_nxt   = (slot_r[0].chop ? ddrrd_pkg::BEATS_BC4
                                         : ddrrd_pkg::BEATS_BL8) - 4'h1;        // [RULE7]
            beat_nxt   = 3'h0;
            dq_nxt     = DQ_W'(slot_r[0].col);
            dq_oe_nxt  = 1'b1;
            dqs_nxt    = 1'b1;
            dqs_oe_nxt = 1'b1;
        end else if (act_pre) begin
            state_nxt  = ddrrd_pkg::ST_PREAM;                                   // [RULE16]
            dq_oe_nxt  = 1'b0;
            dqs_nxt    = 1'b0;
            dqs_oe_nxt = 1'b1;
        end else if (act_stop) begin
            state_nxt  = ddrrd_pkg::ST_IDLE;                                    // [RULE6]
            dq_oe_nxt  = 1'b0;
            dqs_nxt    = 1'b0;
            dqs_oe_nxt = 1'b0;
        end else if (act_beat) begin
            left_nxt   = left_r - 4'h1;
            beat_nxt   = beat_r + 3'h1;
            dq_nxt     = DQ_W'(cur_r.col + {7'h00, beat_r} + 10'h001);
            dqs_nxt    = ck_rise;
        end
    end

    // Pin driver registers
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            state_r  <= ddrrd_pkg::ST_IDLE;
            cur_r    <= '0;
            left_r   <= 4'h0;
            beat_r   <= 3'h0;
            dq_r     <= '0;
            dq_oe_r  <= 1'b0;
            dqs_r    <= 1'b0;
            dqs_oe_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cur_r    <= cur_nxt;
            left_r   <= left_nxt;
            beat_r   <= beat_nxt;
            dq_r     <= dq_nxt;
            dq_oe_r  <= dq_oe_nxt;
            dqs_r    <= dqs_nxt;
            dqs_oe_r <= dqs_oe_nxt;
        end
    end

    // Bank open flags: activate sets, precharge or auto precharge clears, set wins
    generate
        for (g = 0; g < 16; g++) begin : g_bank
            wire set_w = act_take && (cmd_w.bank == 4'(g));
            wire clr_w = (pre_take && (cmd_w.bank == 4'(g))) ||
                         (ap_close && (cur_r.bank == 4'(g)));                   // [RULE5]
            always_ff @(posedge SYS_CLK_I) begin
                if (SYS_RST_I) begin
                    bank_open_r[g] <= 1'b0;
                end else if (set_w || clr_w) begin
                    bank_open_r[g] <= set_w;                                    // [RULE4]
                end
            end
        end
    endgenerate

    // Register writes and accepted read count
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            bl_mode_r <= ddrrd_pkg::BL_RST;
            rpre2_r   <= 1'b0;
            al_mode_r <= ddrrd_pkg::AL_RST;
            cl_r      <= ddrrd_pkg::CL_RST;
            rd_cnt_r  <= 16'h0000;
        end else begin
            if (REG_WR_I && REG_ADDR_I == ddrrd_pkg::REG_CTRL) begin
                bl_mode_r <= REG_WDATA_I[ddrrd_pkg::CTRL_BL_LSB +: 2];          // [RULE3]
                rpre2_r   <= REG_WDATA_I[ddrrd_pkg::CTRL_RPRE_BIT];
                al_mode_r <= REG_WDATA_I[ddrrd_pkg::CTRL_AL_LSB +: 2];
                cl_r      <= REG_WDATA_I[ddrrd_pkg::CTRL_CL_LSB +: ddrrd_pkg::CL_W];
            end
            if (rd_take) begin
                rd_cnt_r <= rd_cnt_r + 16'h0001;
            end
        end
    end

    // Read mux; unmapped offsets answer zero
    wire [31:0] ctrl_rd = {18'h00000, cl_r, 2'h0, al_mode_r, 1'b0, rpre2_r, bl_mode_r};
    wire [31:0] stat_rd = {14'h0000, state_r == ddrrd_pkg::ST_PREAM,
                           state_r == ddrrd_pkg::ST_DATA, bank_open_r};
    wire [31:0] rd_mux  = (REG_ADDR_I == ddrrd_pkg::REG_CTRL) ? ctrl_rd :
                          (REG_ADDR_I == ddrrd_pkg::REG_STAT) ? stat_rd :
                          (REG_ADDR_I == ddrrd_pkg::REG_CNT)  ? {16'h0000, rd_cnt_r} : 32'h0;

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= REG_RD_I ? rd_mux : 32'h0;
        end
    end

    assign REG_RDATA_O = rdata_r;
    assign DQ_O        = dq_r;
    assign DQ_OE_O     = dq_oe_r;
    assign DQS_O       = dqs_r;
    assign DQS_OE_O    = dqs_oe_r;

    // Clock rises seen inside a burst, for checking its length
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            rise_cnt_r <= 3'h0;
        end else if (act_start) begin
            rise_cnt_r <= 3'h0;
        end else if (ck_rise && state_r == ddrrd_pkg::ST_DATA) begin
            rise_cnt_r <= rise_cnt_r + 3'h1;
        end
    end

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    burst_field_a: assert property (rd_take |-> ##1 (slot_r[rl_idx].chop ==  // [RULE3]
        ((bl_mode_r == ddrrd_pkg::BL_FIX4) ||
         (bl_mode_r == ddrrd_pkg::BL_OTF && !$past(cmd_w.addr[ddrrd_pkg::A12_BIT])))))
        else $error("burst chop not taken from mode field");
    otf_select_a: assert property ((rd_take && otf_w && cmd_w.addr[ddrrd_pkg::A12_BIT])  // [RULE2]
        |=> !slot_r[rl_idx].chop && slot_r[rl_idx].vld)
        else $error("on-the-fly high bit did not give full burst");
    read_lat_a: assert property ((al_mode_r == ddrrd_pkg::AL_CL1) |->  // [RULE8]
        (rl_w == {cl_r, 1'b0} - 7'h01))
        else $error("read latency with additive latency wrong");
    bl8_stop_a: assert property ((ck_rise && ending_w && !cur_r.chop) |->  // [RULE6]
        (rise_cnt_r == ddrrd_pkg::CKS_BL8 - 3'h1))
        else $error("eight-beat burst released at wrong clock");
    bc4_stop_a: assert property ((ck_rise && ending_w && cur_r.chop) |->  // [RULE7]
        (rise_cnt_r == ddrrd_pkg::CKS_BC4 - 3'h1))
        else $error("chopped burst released at wrong clock");
    auto_pre_a: assert property ((ap_close && !act_take) |=>  // [RULE5]
        !bank_open_r[$past(cur_r.bank)])
        else $error("auto precharge left bank open");
    plain_read_a: assert property ((ck_rise && ending_w && !cur_r.ap && !pre_take &&  // [RULE4]
        bank_open_r[cur_r.bank]) |=> bank_open_r[$past(cur_r.bank)])
        else $error("plain read closed its bank");
    preamble_a: assert property ((act_start && state_r != ddrrd_pkg::ST_DATA && rl_w > 7'h02)  // [RULE16]
        |-> (state_r == ddrrd_pkg::ST_PREAM) && DQS_OE_O && !DQS_O)
        else $error("burst from idle without strobe preamble");
    start_lat_a: assert property ((act_start) |=> DQ_OE_O && DQS_OE_O && DQS_O)  // [RULE6]
        else $error("burst start did not drive data and strobe");
    seamless_a: assert property ((ck_rise && ending_w && start_w) |=>  // [RULE10]
        (state_r == ddrrd_pkg::ST_DATA) && DQ_OE_O)
        else $error("back to back burst dropped the bus");

    bl8_run_c:   cover property (act_start && !slot_r[0].chop);
    bc4_run_c:   cover property (act_start && slot_r[0].chop);
    auto_pre_c:  cover property (ap_close);
    seamless_c:  cover property (ck_rise && ending_w && start_w);
endmodule
`default_nettype wire

/* bench/ddrrd_ctl_model.sv */
// Memory controller model: makes the command clock and drives the command pins.
// Assumes the bench keeps all command spacing duties when it calls issue.
`timescale 1ns/1ps
`default_nettype none
module ddrrd_ctl_model (
    // Run enable
    input  wire logic        run_i,
    // Command clock and command pins
    output logic             ck_o,
    output logic [2:0]       cmd_o,
    output logic [3:0]       ba_o,
    output logic [13:0]      addr_o
);
    int rises;

    // Odd start offset keeps command clock edges clear of the system clock edges
    initial begin
        ck_o   = 1'b0;
        cmd_o  = 3'h0;
        ba_o   = 4'h0;
        addr_o = 14'h0000;
        rises  = 0;
        #3.3;
        forever begin
            #80;
            ck_o = run_i ? ~ck_o : 1'b0;
        end
    end

    // Rise count tells the bench at which clock a command was taken
    always @(posedge ck_o) rises <= rises + 1;

    // One command, set on a falling edge so it is held a whole clock around the rise
    task automatic issue(input logic [2:0] c, input logic [3:0] b,
                         input logic [13:0] a, output int at);
        @(negedge ck_o);
        cmd_o  <= c;
        ba_o   <= b;
        addr_o <= a;
        at = rises + 1;
        @(negedge ck_o);
        cmd_o  <= ddrrd_pkg::CMD_NOP;
        ba_o   <= ~b;
        addr_o <= ~a;
    endtask
endmodule
`default_nettype wire

/* bench/tb_ddrrd_seq.sv */
// Self-checking bench for the read burst sequencer: random reads in every burst mode.
// Assumes the sequencer and the controller model compile ahead of it.
`timescale 1ns/1ps
`default_nettype none
module tb_ddrrd_seq;
    typedef struct {
        logic [7:0] col;
        int         n;
        int         st;
    } ddrrd_exp_t;
    logic        sys_clk;
    logic        sys_rst;
    logic        run;
    logic        ck;
    logic [2:0]  cmd;
    logic [3:0]  ba;
    logic [13:0] addr;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [7:0]  dq;
    logic        dq_oe;
    logic        dqs;
    logic        dqs_oe;
    logic [1:0]  mode;
    logic [15:0] lfsr;
    logic [15:0] open_b;
    logic        want_d;
    logic        want_s;
    int          errors;
    int          comparisons;
    int          b;
    int          rl;
    int          pre;
    int          now;
    int          total;
    ddrrd_exp_t  q[$];

    always #5 sys_clk = ~sys_clk;

    ddrrd_seq #(.DQ_W(8), .DEPTH(64)) ddrrd_seq_inst (
        .SYS_CLK_I(sys_clk), .SYS_RST_I(sys_rst), .CK_I(ck), .CMD_I(cmd), .BA_I(ba),
        .ADDR_I(addr), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr),
        .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata), .DQ_O(dq), .DQ_OE_O(dq_oe),
        .DQS_O(dqs), .DQS_OE_O(dqs_oe));
    ddrrd_ctl_model ddrrd_ctl_model_inst (
        .run_i(run), .ck_o(ck), .cmd_o(cmd), .ba_o(ba), .addr_o(addr));

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic print_verdict();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Register port: strobes last one cycle, read data is looked at in the cycle after
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        chk(nm, e, reg_rdata);
    endtask

    // Sends one command, books what it should produce, then waits out the spacing
    task automatic send(input logic [2:0] c, input logic [3:0] bk, input logic [13:0] a,
                        input int gap);
        int         at;
        ddrrd_exp_t e;
        ddrrd_ctl_model_inst.issue(c, bk, a, at);
        if (c == ddrrd_pkg::CMD_ACT) open_b[bk] = 1'b1;
        if (c == ddrrd_pkg::CMD_PRE) open_b[bk] = 1'b0;
        if (c == ddrrd_pkg::CMD_RD) begin
            e.col = a[7:0];
            e.n   = (mode == ddrrd_pkg::BL_FIX4 ||
                     (mode == ddrrd_pkg::BL_OTF && !a[12])) ? 4 : 8;
            e.st  = at + rl;
            q.push_back(e);
            open_b[bk] = !a[10];
            total++;
        end
        repeat (gap - 2) @(negedge ck);
    endtask

    // One configuration: latency, preamble and burst mode, then four random reads
    task automatic cfg(input int i);
        int al;
        int cl;
        int g;
        lfsr = nxt(lfsr);
        al   = i % 3;
        cl   = (i == 0) ? 11 : 8 + lfsr[3:0] % 6;
        mode = i[1:0];
        pre  = (i >= 4) ? 2 : 1;
        rl   = (al == 0) ? cl : (al == 1) ? 2 * cl - 1 : 2 * cl - 2;
        wr(ddrrd_pkg::REG_CTRL, {18'h0, 6'(cl), 2'h0, 2'(al), 1'b0, pre == 2, mode});
        for (int k = 0; k < 16; k++) send(ddrrd_pkg::CMD_ACT, 4'(k), 14'h0000, 2);
        for (int k = 0; k < 4; k++) begin
            lfsr = nxt(lfsr);
            g = 4 + lfsr[3:0] % 5;
            if (pre == 2 && g == 5) g = 6;
            if (k == 0) g = 4;
            if (k == 1) g = 4 + pre;
            if (k == 3) g = (i == 0) ? 8 : 2;
            send(ddrrd_pkg::CMD_RD, {2'(k), lfsr[15:14]},
                 {1'b0, lfsr[12], 1'b0, lfsr[10], lfsr[9:0]}, g);
        end
        // Write uses a one-clock write preamble, so write latency may stay at its lowest
        if (i == 0) send(ddrrd_pkg::CMD_WR, 4'h1, 14'h0000, 2);
        for (int w = 0; w < 8000 && q.size() > 0; w++) @(posedge sys_clk);
        repeat (48) @(posedge sys_clk);
        rd(ddrrd_pkg::REG_STAT, {16'h0, open_b}, "stat_banks");
        rd(ddrrd_pkg::REG_CNT, {16'h0, 16'(total)}, "read_count");
    endtask

    // Pin checker, sampled well after each command clock edge once outputs settle
    always @(ck) begin
        #60;
        now    = ddrrd_ctl_model_inst.rises;
        want_d = q.size() > 0 && now >= q[0].st;
        want_s = q.size() > 0 && now >= q[0].st - pre;
        chk("dq_oe", {31'h0, want_d}, {31'h0, dq_oe});
        chk("dqs_oe", {31'h0, want_s}, {31'h0, dqs_oe});
        if (want_d) begin
            chk("dq", {24'h0, q[0].col + 8'(b)}, {24'h0, dq});
            chk("dqs", {31'h0, ck}, {31'h0, dqs});
            b++;
            if (b == q[0].n) begin
                b = 0;
                q.delete(0);
            end
        end else if (want_s) begin
            chk("dqs_pre", 32'h0, {31'h0, dqs});
        end
    end

    // Watchdog: the whole run needs well under half of this
    initial begin
        #400_000;
        errors++;
        print_verdict();
    end

    initial begin
        sys_clk   = 1'b0;
        sys_rst   = 1'b1;
        run       = 1'b0;
        reg_addr  = 4'h0;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        mode      = 2'h0;
        lfsr      = 16'hf9f8;
        open_b    = 16'h0000;
        errors    = 0;
        comparisons = 0;
        b = 0;
        rl = 11;
        pre = 1;
        total = 0;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        run <= 1'b1;
        rd(ddrrd_pkg::REG_CTRL, 32'h00000b00, "ctrl_reset");
        rd(ddrrd_pkg::REG_STAT, 32'h0, "stat_reset");
        wr(4'hc, 32'hffffffff);
        rd(4'hc, 32'h0, "unmapped");
        rd(ddrrd_pkg::REG_CTRL, 32'h00000b00, "ctrl_kept");
        for (int i = 0; i < 8; i++) cfg(i);
        send(ddrrd_pkg::CMD_PRE, 4'h0, 14'h0000, 4);
        repeat (16) @(posedge sys_clk);
        rd(ddrrd_pkg::REG_STAT, {16'h0, open_b}, "stat_pre");
        print_verdict();
    end
endmodule
`default_nettype wire
